// >>> pkg/fbtc_map.vh
// Contract
// - Analog values scale so 0x4000 equals reference.
// - Control and status words are two bytes.
// - Addresses 1..125 valid; valid switches block writes.
// - Switches all zeros or ones: use stored.
// - New address active only after power cycle; reset reloads stored address 0x03, so a written one never applies.
// - Export command 12 with card copies description.
// - Telegram selection defaults to code 1.
// - Accept telegram codes 1,20,350,352,353,354,999.
// - Telegram code write sets word routing automatically.
// - Routing changes only while telegram code is 999.
// - Below 999, extended mirrors code, writes rejected.
// - At 999 extended writable; 999 frees routing.
// - At 999 with base telegram, extensions only.
// - I/O macro 7 selects fieldbus command configuration.
`ifndef FBTC_MAP_VH
`define FBTC_MAP_VH

// ****************************************************************
// Register offsets (word addresses on the plain register port).
// ****************************************************************
`define FBTC_REG_ADDR_STORED 4'h0
`define FBTC_REG_TELEGRAM 4'h1
`define FBTC_REG_EXTENDED 4'h2
`define FBTC_REG_CARD_CMD 4'h3
`define FBTC_REG_IO_MACRO 4'h4
`define FBTC_REG_STATUS 4'h5
`define FBTC_REG_ROUTE_IDX 4'h6
`define FBTC_REG_ROUTE_SRC 4'h7
`define FBTC_REG_SCALE_REF 4'h8
`define FBTC_REG_SCALE_VAL 4'h9
`define FBTC_REG_SCALE_OUT 4'ha
`define FBTC_REG_CTRL_WORD 4'hb

// ****************************************************************
// Codes and reset values.
// ****************************************************************
`define FBTC_TEL_STD1 10'h001
`define FBTC_TEL_STD20 10'h014
`define FBTC_TEL_350 10'h15e
`define FBTC_TEL_352 10'h160
`define FBTC_TEL_353 10'h161
`define FBTC_TEL_354 10'h162
`define FBTC_TEL_FREE 10'h3e7
`define FBTC_CARD_EXPORT 8'h0c
`define FBTC_MACRO_FIELDBUS 8'h07
`define FBTC_ADDR_MAX 7'h7d
`define FBTC_FULL_SCALE 16'h4000
`define FBTC_ROUTE_WORDS 8
`define FBTC_STORED_RESET 7'h03

// ****************************************************************
// Status register bit positions.
// ****************************************************************
`define FBTC_ST_SW_VALID 0
`define FBTC_ST_ROUTE_FREE 1
`define FBTC_ST_EXPORT_BUSY 2
`define FBTC_ST_FIELDBUS_IO 3
`define FBTC_ST_REJECT 4
`define FBTC_ST_CHAN 5

`endif

// >>> logic/fbtc_scale.v
`timescale 1ns/100ps
`include "fbtc_map.vh"

// Normalises a physical value so that the reference maps to full scale.
module fbtc_scale #(
    parameter WIDTH = 16
) (
    input wire CLOCK,
    input wire RST_N,
    input wire [WIDTH-1:0] REF_VALUE,
    input wire [WIDTH-1:0] PHYS_VALUE,
    output reg [WIDTH-1:0] SCALED
);

    // Product of value and full scale before division.
    wire [2*WIDTH-1:0] product;
    // Quotient kept wide so overflow can be clipped.
    wire [2*WIDTH-1:0] quotient;

    assign product = PHYS_VALUE * `FBTC_FULL_SCALE;
    // A zero reference would divide by zero, so full scale is reported instead.
    assign quotient = (REF_VALUE == {WIDTH{1'b0}}) ? {{WIDTH{1'b0}}, `FBTC_FULL_SCALE} :
                      product / REF_VALUE;

    // ****************************************************************
    // Output register, saturating at the largest code.
    // ****************************************************************
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            SCALED <= {WIDTH{1'b0}};
        end else if (|quotient[2*WIDTH-1:WIDTH]) begin
            SCALED <= {WIDTH{1'b1}};
        end else begin
            SCALED <= quotient[WIDTH-1:0];
        end
    end

endmodule

// >>> logic/fbtc_config.v
`timescale 1ns/100ps
`include "fbtc_map.vh"

// Fieldbus telegram and address configuration of the slave port.
module fbtc_config #(
    parameter ROUTE_WORDS = `FBTC_ROUTE_WORDS
) (
    input wire CLOCK,
    input wire RST_N,
    input wire [6:0] ADDR_SWITCH,
    input wire CARD_PRESENT,
    input wire EXPORT_DONE,
    input wire [3:0] REG_ADDR,
    input wire [15:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    input wire BYTE_SWAP,
    input wire [15:0] CTRL_WORD_IN,
    output reg [15:0] REG_RDATA,
    output reg [6:0] BUS_ADDRESS,
    output reg EXPORT_START,
    output reg FIELDBUS_IO,
    output reg [3:0] RX_WORDS,
    output reg [3:0] TX_WORDS,
    output reg PARAM_CHAN,
    output reg [15:0] CTRL_WORD_OUT
);

    // ****************************************************************
    // Declarations.
    // ****************************************************************
    reg [6:0] sw_meta_q; // First synchroniser stage, read only by sw_sync_q.
    reg [6:0] sw_sync_q; // Synchronised switch bank.
    reg [6:0] stored_bus_address_q; // Software stored address.
    reg [9:0] telegram_select_code_q; // Base telegram code.
    reg [9:0] extended_telegram_select_q; // Extended telegram code.
    reg [7:0] card_export_command_q; // Card export command setting.
    reg [7:0] io_macro_select_q; // I/O macro selection.
    reg export_busy_q; // Export in progress.
    reg reject_q; // Last write was refused; sticky until status read.
    reg [2:0] route_idx_q; // Routing index pointer.
    reg [7:0] signal_routing_q [0:ROUTE_WORDS-1]; // Source per word.
    reg [3:0] base_words_q; // Words locked by the base telegram.
    reg [15:0] scale_ref_q; // Reference for normalisation.
    reg [15:0] scale_val_q; // Physical value to normalise.
    reg [1:0] boot_q; // Counts the first two edges after reset release.
    wire [15:0] scaled; // Normalised value.
    wire sw_valid; // Switch address usable.
    wire route_free; // All routing writable.
    wire route_wr_ok; // Current routing index writable.
    wire wr_rejected; // This cycle's write is refused.
    integer i;

    // Address validity check used for both sources.
    function addr_ok;
        input [6:0] a;
        begin
            addr_ok = (a != 7'h00) && (a <= `FBTC_ADDR_MAX);
        end
    endfunction

    // Accepted telegram codes.
    function code_ok;
        input [9:0] c;
        begin
            code_ok = (c == `FBTC_TEL_STD1) || (c == `FBTC_TEL_STD20) ||
                      (c == `FBTC_TEL_350) || (c == `FBTC_TEL_352) ||
                      (c == `FBTC_TEL_353) || (c == `FBTC_TEL_354) ||
                      (c == `FBTC_TEL_FREE);
        end
    endfunction

    // Receive word count of a telegram; free code gives the maximum.
    function [3:0] rx_len;
        input [9:0] c;
        begin
            case (c)
                `FBTC_TEL_STD1: rx_len = 4'h2;
                `FBTC_TEL_STD20: rx_len = 4'h2;
                `FBTC_TEL_350: rx_len = 4'h4;
                `FBTC_TEL_352: rx_len = 4'h6;
                `FBTC_TEL_353: rx_len = 4'h2;
                `FBTC_TEL_354: rx_len = 4'h6;
                default: rx_len = 4'h8;
            endcase
        end
    endfunction

    // Transmit word count of a telegram.
    function [3:0] tx_len;
        input [9:0] c;
        begin
            case (c)
                `FBTC_TEL_STD20: tx_len = 4'h6;
                default: tx_len = rx_len(c);
            endcase
        end
    endfunction

    // Parameter channel present for the two combined telegrams.
    function has_chan;
        input [9:0] c;
        begin
            has_chan = (c == `FBTC_TEL_353) || (c == `FBTC_TEL_354);
        end
    endfunction

    // ****************************************************************
    // Switch synchroniser.
    // ****************************************************************
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            sw_meta_q <= 7'h00;
            sw_sync_q <= 7'h00;
        end else begin
            sw_meta_q <= ADDR_SWITCH;
            sw_sync_q <= sw_meta_q;
        end
    end

    // All zeros is invalid anyway; all ones is 127, also invalid.
    assign sw_valid = addr_ok(sw_sync_q);
    assign route_free = (telegram_select_code_q == `FBTC_TEL_FREE) &&
                        (extended_telegram_select_q == `FBTC_TEL_FREE);
    // Under an extended base telegram only appended words are writable.
    assign route_wr_ok = route_free ||
                         ((telegram_select_code_q == `FBTC_TEL_FREE) &&
                          ({1'b0, route_idx_q} >= base_words_q));
    assign wr_rejected = REG_WR && (
        ((REG_ADDR == `FBTC_REG_ADDR_STORED) && sw_valid) ||
        ((REG_ADDR == `FBTC_REG_ADDR_STORED) && !addr_ok(REG_WDATA[6:0])) ||
        ((REG_ADDR == `FBTC_REG_TELEGRAM) && !code_ok(REG_WDATA[9:0])) ||
        ((REG_ADDR == `FBTC_REG_EXTENDED) &&
         ((telegram_select_code_q != `FBTC_TEL_FREE) || !code_ok(REG_WDATA[9:0]))) ||
        ((REG_ADDR == `FBTC_REG_ROUTE_SRC) && !route_wr_ok));

    // ****************************************************************
    // Settings registers.
    // ****************************************************************
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            stored_bus_address_q <= `FBTC_STORED_RESET;
            telegram_select_code_q <= `FBTC_TEL_STD1;
            extended_telegram_select_q <= `FBTC_TEL_STD1;
            card_export_command_q <= 8'h00;
            io_macro_select_q <= 8'h00;
            route_idx_q <= 3'h0;
            scale_ref_q <= 16'h0000;
            scale_val_q <= 16'h0000;
            base_words_q <= 4'h2;
        end else if (REG_WR && !wr_rejected) begin
            case (REG_ADDR)
                `FBTC_REG_ADDR_STORED: begin
                    stored_bus_address_q <= REG_WDATA[6:0];
                end
                `FBTC_REG_TELEGRAM: begin
                    telegram_select_code_q <= REG_WDATA[9:0];
                    // The extended selection follows a fixed code.
                    extended_telegram_select_q <= REG_WDATA[9:0];
                    base_words_q <= rx_len(REG_WDATA[9:0]);
                end
                `FBTC_REG_EXTENDED: begin
                    extended_telegram_select_q <= REG_WDATA[9:0];
                    base_words_q <= (REG_WDATA[9:0] == `FBTC_TEL_FREE) ? 4'h0 :
                                    rx_len(REG_WDATA[9:0]);
                end
                `FBTC_REG_CARD_CMD: begin
                    card_export_command_q <= REG_WDATA[7:0];
                end
                `FBTC_REG_IO_MACRO: begin
                    io_macro_select_q <= REG_WDATA[7:0];
                end
                `FBTC_REG_ROUTE_IDX: begin
                    route_idx_q <= REG_WDATA[2:0];
                end
                `FBTC_REG_SCALE_REF: begin
                    scale_ref_q <= REG_WDATA;
                end
                `FBTC_REG_SCALE_VAL: begin
                    scale_val_q <= REG_WDATA;
                end
                default: begin
                    route_idx_q <= route_idx_q;
                end
            endcase
        end
    end

    // ****************************************************************
    // Word routing table.
    // ****************************************************************
    // A telegram code write reloads the default routing: word n takes source n.
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            for (i = 0; i < ROUTE_WORDS; i = i + 1) begin
                signal_routing_q[i] <= i[7:0];
            end
        end else if (REG_WR && !wr_rejected && (REG_ADDR == `FBTC_REG_TELEGRAM)) begin
            for (i = 0; i < ROUTE_WORDS; i = i + 1) begin
                signal_routing_q[i] <= i[7:0];
            end
        end else if (REG_WR && !wr_rejected && (REG_ADDR == `FBTC_REG_ROUTE_SRC)) begin
            signal_routing_q[route_idx_q] <= REG_WDATA[7:0];
        end
    end

    // ****************************************************************
    // Card export and reject flag.
    // ****************************************************************
    // The command starts an export whenever none is busy and a card is present; busy clears when the card side is done or the card is pulled.
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            export_busy_q <= 1'b0;
            EXPORT_START <= 1'b0;
            reject_q <= 1'b0;
        end else begin
            EXPORT_START <= 1'b0;
            if (!export_busy_q && CARD_PRESENT &&
                (card_export_command_q == `FBTC_CARD_EXPORT)) begin
                export_busy_q <= 1'b1;
                EXPORT_START <= 1'b1;
            end else if (export_busy_q && (EXPORT_DONE || !CARD_PRESENT)) begin
                export_busy_q <= 1'b0;
            end
            // A refusal in the same cycle as the clearing read wins.
            if (wr_rejected) begin
                reject_q <= 1'b1;
            end else if (REG_RD && (REG_ADDR == `FBTC_REG_STATUS)) begin
                reject_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Bus address, latched once after reset release.
    // ****************************************************************
    // Reset stands for a power cycle, so later switch changes wait for the next one; it also reloads the stored address.
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            boot_q <= 2'h0;
            BUS_ADDRESS <= 7'h00;
        end else begin
            if (boot_q != 2'h2) begin
                boot_q <= boot_q + 2'h1;
            end
            // The synchroniser fills on edges one and two, so capture on the third.
            if (boot_q != 2'h2) begin
                BUS_ADDRESS <= 7'h00;
            end else if (BUS_ADDRESS == 7'h00) begin
                BUS_ADDRESS <= sw_valid ? sw_sync_q : stored_bus_address_q;
            end
        end
    end

    // ****************************************************************
    // Telegram outputs and control word byte order.
    // ****************************************************************
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            RX_WORDS <= 4'h2;
            TX_WORDS <= 4'h2;
            PARAM_CHAN <= 1'b0;
            FIELDBUS_IO <= 1'b0;
            CTRL_WORD_OUT <= 16'h0000;
        end else begin
            RX_WORDS <= rx_len(extended_telegram_select_q);
            TX_WORDS <= tx_len(extended_telegram_select_q);
            PARAM_CHAN <= has_chan(extended_telegram_select_q);
            FIELDBUS_IO <= (io_macro_select_q == `FBTC_MACRO_FIELDBUS);
            // Byte order is agreed per controller, so the BYTE_SWAP input chooses it.
            CTRL_WORD_OUT <= BYTE_SWAP ? {CTRL_WORD_IN[7:0], CTRL_WORD_IN[15:8]} :
                             CTRL_WORD_IN;
        end
    end

    // ****************************************************************
    // Normaliser.
    // ****************************************************************
    fbtc_scale #(
        .WIDTH(16)
    ) u_scale (
        .CLOCK(CLOCK),
        .RST_N(RST_N),
        .REF_VALUE(scale_ref_q),
        .PHYS_VALUE(scale_val_q),
        .SCALED(scaled)
    );

    // ****************************************************************
    // Read data, one cycle after the read strobe; zero otherwise.
    // ****************************************************************
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            REG_RDATA <= 16'h0000;
        end else if (REG_RD) begin
            case (REG_ADDR)
                `FBTC_REG_ADDR_STORED: REG_RDATA <= {9'h000, stored_bus_address_q};
                `FBTC_REG_TELEGRAM: REG_RDATA <= {6'h00, telegram_select_code_q};
                `FBTC_REG_EXTENDED: REG_RDATA <= {6'h00, extended_telegram_select_q};
                `FBTC_REG_CARD_CMD: REG_RDATA <= {8'h00, card_export_command_q};
                `FBTC_REG_IO_MACRO: REG_RDATA <= {8'h00, io_macro_select_q};
                `FBTC_REG_STATUS: begin
                    REG_RDATA <= {10'h000, PARAM_CHAN, reject_q, FIELDBUS_IO,
                                  export_busy_q, route_free, sw_valid};
                end
                `FBTC_REG_ROUTE_IDX: REG_RDATA <= {13'h0000, route_idx_q};
                `FBTC_REG_ROUTE_SRC: REG_RDATA <= {8'h00, signal_routing_q[route_idx_q]};
                `FBTC_REG_SCALE_REF: REG_RDATA <= scale_ref_q;
                `FBTC_REG_SCALE_VAL: REG_RDATA <= scale_val_q;
                `FBTC_REG_SCALE_OUT: REG_RDATA <= scaled;
                `FBTC_REG_CTRL_WORD: REG_RDATA <= CTRL_WORD_OUT;
                default: REG_RDATA <= 16'h0000;
            endcase
        end else begin
            REG_RDATA <= 16'h0000;
        end
    end

endmodule

// >>> testbench/fbtc_config_sva.sv
`timescale 1ns/100ps

// ****************************************************************
// Port checker for the telegram and address configuration.
// ****************************************************************
module fbtc_config_sva (
    input wire CLOCK,
    input wire RST_N,
    input wire [3:0] REG_ADDR,
    input wire [15:0] REG_WDATA,
    input wire REG_WR,
    input wire CARD_PRESENT,
    input wire BYTE_SWAP,
    input wire [15:0] CTRL_WORD_IN,
    input wire [6:0] BUS_ADDRESS,
    input wire EXPORT_START,
    input wire FIELDBUS_IO,
    input wire [3:0] RX_WORDS,
    input wire [3:0] TX_WORDS,
    input wire PARAM_CHAN,
    input wire [15:0] CTRL_WORD_OUT
);
    // One domain, so clock and reset are given once.
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    a_addr_latch: assert property ($rose(RST_N) |-> ##[1:4] BUS_ADDRESS != 7'h00)
        else $error("bus address not latched after reset");
    a_addr_range: assert property (BUS_ADDRESS != 7'h00 |-> BUS_ADDRESS <= 7'h7d)
        else $error("bus address outside valid range");
    a_addr_frozen: assert property (BUS_ADDRESS != 7'h00 |=> $stable(BUS_ADDRESS))
        else $error("bus address changed without power cycle");
    a_export_pulse: assert property (EXPORT_START |=> !EXPORT_START)
        else $error("export start longer than one cycle");
    a_export_card: assert property (EXPORT_START |-> $past(CARD_PRESENT))
        else $error("export started without a card");
    a_io_macro: assert property (REG_WR && REG_ADDR == 4'h4 |->
        ##2 FIELDBUS_IO == ($past(REG_WDATA[7:0], 2) == 8'h07))
        else $error("fieldbus io flag does not follow macro");
    a_tel_route: assert property (REG_WR && REG_ADDR == 4'h1 &&
        REG_WDATA == 16'h015e |-> ##2 RX_WORDS == 4'h4 && TX_WORDS == 4'h4)
        else $error("word counts wrong after code 350");
    a_tel_param: assert property (REG_WR && REG_ADDR == 4'h1 &&
        REG_WDATA == 16'h0162 |-> ##2 PARAM_CHAN && RX_WORDS == 4'h6)
        else $error("parameter channel missing after code 354");
    a_ctrl_order: assert property ($past(RST_N) |->
        CTRL_WORD_OUT == ($past(BYTE_SWAP) ? {$past(CTRL_WORD_IN[7:0]),
        $past(CTRL_WORD_IN[15:8])} : $past(CTRL_WORD_IN)))
        else $error("control word byte order wrong");
endmodule

bind fbtc_config fbtc_config_sva u_sva (.CLOCK(CLOCK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .CARD_PRESENT(CARD_PRESENT),
    .BYTE_SWAP(BYTE_SWAP), .CTRL_WORD_IN(CTRL_WORD_IN), .BUS_ADDRESS(BUS_ADDRESS),
    .EXPORT_START(EXPORT_START), .FIELDBUS_IO(FIELDBUS_IO), .RX_WORDS(RX_WORDS),
    .TX_WORDS(TX_WORDS), .PARAM_CHAN(PARAM_CHAN), .CTRL_WORD_OUT(CTRL_WORD_OUT));

// >>> testbench/fbtc_card_model.sv
`timescale 1ns/100ps

// ****************************************************************
// Memory card side: takes a copy request and reports completion.
// ****************************************************************
module fbtc_card_model #(
    parameter DONE_DELAY = 6
) (
    input wire clock,
    input wire rst_n,
    input wire card_in,
    input wire export_start,
    output reg card_present,
    output reg export_done
);
    int count_q; // Cycles left in the copy; zero while idle.

    // The copy takes a while, so the device must wait for the done pulse.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 0;
            export_done <= 1'b0;
        end else if (export_start && card_in) begin
            count_q <= DONE_DELAY;
            export_done <= 1'b0;
        end else begin
            count_q <= (count_q > 0) ? count_q - 1 : 0;
            export_done <= card_in && (count_q == 1);
        end
    end

    // Card detection is a plain level in the same clock domain.
    always @* begin
        card_present = card_in;
    end
endmodule

// >>> testbench/tb_fieldbus_telegram_config.sv
`timescale 1ns/100ps
`include "fbtc_map.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_fieldbus_telegram_config;
    logic CLOCK, RST_N, REG_WR, REG_RD, BYTE_SWAP, CARD_PRESENT, EXPORT_DONE, EXPORT_START;
    logic FIELDBUS_IO, PARAM_CHAN, card_in;
    logic [6:0] ADDR_SWITCH, BUS_ADDRESS;
    logic [3:0] REG_ADDR, RX_WORDS, TX_WORDS;
    logic [15:0] REG_WDATA, CTRL_WORD_IN, REG_RDATA, CTRL_WORD_OUT, v;
    int fails = 0;
    int total_checks = 0;
    int pulses = 0;

    fbtc_config uut (.CLOCK(CLOCK), .RST_N(RST_N), .ADDR_SWITCH(ADDR_SWITCH),
        .CARD_PRESENT(CARD_PRESENT), .EXPORT_DONE(EXPORT_DONE), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .BYTE_SWAP(BYTE_SWAP),
        .CTRL_WORD_IN(CTRL_WORD_IN), .REG_RDATA(REG_RDATA), .BUS_ADDRESS(BUS_ADDRESS),
        .EXPORT_START(EXPORT_START), .FIELDBUS_IO(FIELDBUS_IO), .RX_WORDS(RX_WORDS),
        .TX_WORDS(TX_WORDS), .PARAM_CHAN(PARAM_CHAN), .CTRL_WORD_OUT(CTRL_WORD_OUT));
    fbtc_card_model card (.clock(CLOCK), .rst_n(RST_N), .card_in(card_in),
        .export_start(EXPORT_START), .card_present(CARD_PRESENT), .export_done(EXPORT_DONE));

    // ****************************************************************
    // Clock, pulse counter and bus tasks.
    // ****************************************************************
    initial begin
        CLOCK = 1'b0;
        forever #25 CLOCK = ~CLOCK;
    end

    always @(posedge CLOCK) begin
        if (EXPORT_START === 1'b1) pulses <= pulses + 1;
    end

    // Waits whole cycles and steps past the edge so outputs have settled.
    task automatic tick(input int n);
        repeat (n) @(posedge CLOCK);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge CLOCK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge CLOCK);
        REG_WR <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge CLOCK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CLOCK);
        REG_RD <= 1'b0;
        #1;
        d = REG_RDATA;
    endtask

    task automatic chk_rd(input logic [3:0] a, input logic [15:0] e);
        logic [15:0] d;
        rd(a, d);
        `CHK(d, e)
    endtask

    task automatic do_reset(input logic [6:0] sw);
        ADDR_SWITCH <= sw;
        RST_N <= 1'b0;
        repeat (16) @(posedge CLOCK);
        RST_N <= 1'b1;
        tick(5);
    endtask

    // ****************************************************************
    // Scenarios.
    // ****************************************************************
    task automatic t_telegram;
        logic [15:0] codes [7];
        logic [3:0] rxs [7];
        logic [3:0] txs [7];
        codes = '{16'h0001, 16'h0014, 16'h015e, 16'h0160, 16'h0161, 16'h0162, 16'h03e7};
        rxs = '{4'h2, 4'h2, 4'h4, 4'h6, 4'h2, 4'h6, 4'h8};
        txs = '{4'h2, 4'h6, 4'h4, 4'h6, 4'h2, 4'h6, 4'h8};
        chk_rd(`FBTC_REG_TELEGRAM, 16'h0001);
        `CHK(RX_WORDS, 4'h2)
        for (int i = 0; i < 7; i++) begin
            wr(`FBTC_REG_TELEGRAM, codes[i]);
            tick(2);
            `CHK(RX_WORDS, rxs[i])
            `CHK(TX_WORDS, txs[i])
            `CHK(PARAM_CHAN, (i == 4 || i == 5))
            chk_rd(`FBTC_REG_EXTENDED, codes[i]);
        end
        wr(`FBTC_REG_TELEGRAM, 16'h0002);
        chk_rd(`FBTC_REG_TELEGRAM, 16'h03e7);
        rd(`FBTC_REG_STATUS, v);
        `CHK(v[`FBTC_ST_REJECT], 1'b1)
    endtask

    // Base telegram locks its words; free mode opens them, extensions only the appended ones.
    task automatic t_routing;
        wr(`FBTC_REG_TELEGRAM, 16'h015e);
        wr(`FBTC_REG_EXTENDED, 16'h03e7);
        chk_rd(`FBTC_REG_EXTENDED, 16'h015e);
        wr(`FBTC_REG_ROUTE_IDX, 16'h0002);
        wr(`FBTC_REG_ROUTE_SRC, 16'h0055);
        chk_rd(`FBTC_REG_ROUTE_SRC, 16'h0002);
        wr(`FBTC_REG_TELEGRAM, 16'h03e7);
        wr(`FBTC_REG_ROUTE_SRC, 16'h0055);
        chk_rd(`FBTC_REG_ROUTE_SRC, 16'h0055);
        wr(`FBTC_REG_EXTENDED, 16'h015e);
        chk_rd(`FBTC_REG_EXTENDED, 16'h015e);
        wr(`FBTC_REG_ROUTE_IDX, 16'h0001);
        wr(`FBTC_REG_ROUTE_SRC, 16'h0066);
        chk_rd(`FBTC_REG_ROUTE_SRC, 16'h0001);
        wr(`FBTC_REG_ROUTE_IDX, 16'h0005);
        wr(`FBTC_REG_ROUTE_SRC, 16'h0066);
        chk_rd(`FBTC_REG_ROUTE_SRC, 16'h0066);
        wr(`FBTC_REG_TELEGRAM, 16'h0001);
        chk_rd(`FBTC_REG_ROUTE_SRC, 16'h0005);
    endtask

    task automatic t_export;
        card_in <= 1'b1;
        tick(2);
        wr(`FBTC_REG_CARD_CMD, 16'h000b);
        tick(8);
        `CHK(pulses, 0)
        wr(`FBTC_REG_CARD_CMD, 16'h000c);
        wr(`FBTC_REG_CARD_CMD, 16'h0000);
        tick(16);
        `CHK(pulses, 1)
        card_in <= 1'b0;
        wr(`FBTC_REG_CARD_CMD, 16'h000c);
        tick(8);
        `CHK(pulses, 1)
        wr(`FBTC_REG_CARD_CMD, 16'h0000);
    endtask

    task automatic t_misc;
        wr(`FBTC_REG_IO_MACRO, 16'h0007);
        tick(2);
        `CHK(FIELDBUS_IO, 1'b1)
        wr(`FBTC_REG_IO_MACRO, 16'h0003);
        tick(2);
        `CHK(FIELDBUS_IO, 1'b0)
        wr(`FBTC_REG_SCALE_REF, 16'h1000);
        wr(`FBTC_REG_SCALE_VAL, 16'h0800);
        tick(3);
        chk_rd(`FBTC_REG_SCALE_OUT, 16'h2000);
        wr(`FBTC_REG_SCALE_VAL, 16'h1000);
        tick(3);
        chk_rd(`FBTC_REG_SCALE_OUT, `FBTC_FULL_SCALE);
        CTRL_WORD_IN <= 16'h12a4;
        tick(2);
        `CHK(CTRL_WORD_OUT, 16'h12a4)
        BYTE_SWAP <= 1'b1;
        tick(2);
        chk_rd(`FBTC_REG_CTRL_WORD, 16'ha412);
        chk_rd(4'hf, 16'h0000);
    endtask

    // Switch bank against stored setting, and the power-cycle rule.
    task automatic t_address;
        logic [6:0] sws [6];
        logic [6:0] exps [6];
        sws = '{7'h00, 7'h7f, 7'h7e, 7'h01, 7'h7d, 7'h0a};
        exps = '{7'h03, 7'h03, 7'h03, 7'h01, 7'h7d, 7'h0a};
        for (int i = 0; i < 6; i++) begin
            do_reset(sws[i]);
            `CHK(BUS_ADDRESS, exps[i])
        end
        wr(`FBTC_REG_ADDR_STORED, 16'h0020);
        chk_rd(`FBTC_REG_ADDR_STORED, {9'h000, `FBTC_STORED_RESET});
        do_reset(7'h7e);
        wr(`FBTC_REG_ADDR_STORED, 16'h0020);
        chk_rd(`FBTC_REG_ADDR_STORED, 16'h0020);
        wr(`FBTC_REG_ADDR_STORED, 16'h007e);
        chk_rd(`FBTC_REG_ADDR_STORED, 16'h0020);
        ADDR_SWITCH <= 7'h0a;
        tick(4);
        `CHK(BUS_ADDRESS, `FBTC_STORED_RESET)
        do_reset(7'h0a);
        `CHK(BUS_ADDRESS, 7'h0a)
    endtask

    // ****************************************************************
    // Verdict, watchdog and main sequence.
    // ****************************************************************
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // The whole run needs under 3000 cycles; this leaves wide margin.
    initial begin
        repeat (20000) @(posedge CLOCK);
        fails++;
        complete_run();
    end

    initial begin
        RST_N = 1'b0;
        ADDR_SWITCH = 7'h00;
        REG_ADDR = 4'h0;
        REG_WDATA = 16'h0000;
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        BYTE_SWAP = 1'b0;
        CTRL_WORD_IN = 16'h0000;
        card_in = 1'b0;
        do_reset(7'h00);
        t_telegram();
        t_routing();
        t_export();
        t_misc();
        t_address();
        complete_run();
    end
endmodule
